// ==== hw/flash_cmd_sequence_decoder.sv ====
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"

// Behaviour
// - buffer load: unlock, 25h, count, data words
// - 29h at same sector starts buffer program
// - unlock then F0h leaves aborted buffer state
// - six-cycle chip erase ending 10h at 555h
// - same five cycles, 30h erases addressed sector
// - 33h at sector plus 555h: blank check
// - D0h at sector plus 555h: erase status
// - B0h anywhere suspends erase
// - lone 30h anywhere resumes erase
// - 51h anywhere suspends program
// - 50h anywhere resumes program
// - AAh, 55h, 90h enter identification space
// - 98h at 555h enters identification space
// - transaction type 001b in top bits
// - compare low address bits, device select
module flash_cmd_sequence_decoder (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic link_clk,
	input wire logic link_sel_n,
	input wire logic link_reset_n,
	input wire logic [`CA_W-1:0] ca_pins,
	input wire logic [`DQ_W-1:0] dq_pins,
	output logic buffer_program_start,
	output logic chip_erase_start,
	output logic sector_erase_start,
	output logic blank_check_start,
	output logic erase_status_start,
	output logic erase_suspend_req,
	output logic erase_resume_req,
	output logic program_suspend_req,
	output logic program_resume_req,
	output logic id_space_enter,
	output logic buffer_abort_done,
	output logic buffer_word_strobe,
	output logic [`ADDR_W-1:0] buffer_location_addr,
	output logic [`DQ_W-1:0] program_word,
	output logic [`SECT_W-1:0] op_sector_addr,
	output logic [`DQ_W-1:0] buffer_word_count,
	output logic buffer_aborted,
	output logic seq_busy
);
	import flash_cmd_pkg::*;

	logic [`PIN_W-1:0] pins_sync;
	logic lclk_s, lsel_n_s, lrst_n_s, lclk_prev_reg, take;
	logic [`CA_W-1:0] ca_s;
	logic [`DQ_W-1:0] dq_s;
	logic cyc_reg, fit_reg, lo555_reg, lo2aa_reg;
	logic [`CODE_W-1:0] code_reg;
	logic [`DQ_W-1:0] word_reg;
	logic [`ADDR_W-1:0] addr_reg;
	logic [`SECT_W-1:0] sector_reg;
	decoder_state_type state_reg, state_next;
	logic [`SECT_W-1:0] load_sector_reg;
	logic [`DQ_W-1:0] left_reg;
	logic same_sector, is_code_aa, is_code_55;
	logic ev_prog, ev_chip, ev_sect, ev_blank, ev_status, ev_esusp, ev_eres;
	logic ev_psusp, ev_pres, ev_id, ev_abort_done, ev_word, ld_sector, ld_count;

	pin_sync u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pins({link_reset_n, link_sel_n, link_clk, ca_pins, dq_pins}),
		.pins_sync(pins_sync)
	);

	assign {lrst_n_s, lsel_n_s, lclk_s, ca_s, dq_s} = pins_sync;

	// the link clock is sampled; host holds the word around its rising edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lclk_prev_reg <= 1'b0;
		end else begin
			lclk_prev_reg <= lclk_s;
		end
	end

	assign take = lclk_s && !lclk_prev_reg && !lsel_n_s;

	cycle_fields u_fields (
		.mclk(mclk),
		.reset_n(reset_n),
		.take(take),
		.ca(ca_s),
		.dq(dq_s),
		.cyc_reg(cyc_reg),
		.fit_reg(fit_reg),
		.lo555_reg(lo555_reg),
		.lo2aa_reg(lo2aa_reg),
		.code_reg(code_reg),
		.word_reg(word_reg),
		.addr_reg(addr_reg),
		.sector_reg(sector_reg)
	);

	assign same_sector = (sector_reg == load_sector_reg);
	assign is_code_aa = fit_reg && lo555_reg && (code_reg == `CODE_UNLOCK1);
	assign is_code_55 = fit_reg && lo2aa_reg && (code_reg == `CODE_UNLOCK2);

	always_comb begin
		state_next = state_reg;
		ev_prog = 1'b0;
		ev_chip = 1'b0;
		ev_sect = 1'b0;
		ev_blank = 1'b0;
		ev_status = 1'b0;
		ev_esusp = 1'b0;
		ev_eres = 1'b0;
		ev_psusp = 1'b0;
		ev_pres = 1'b0;
		ev_id = 1'b0;
		ev_abort_done = 1'b0;
		ev_word = 1'b0;
		ld_sector = 1'b0;
		ld_count = 1'b0;
		if (cyc_reg) begin
			unique case (state_reg)
				ST_IDLE: begin
					if (is_code_aa) begin
						state_next = ST_UNLOCK1;
					end else if (fit_reg) begin
						unique case (code_reg)
							`CODE_ID_QUICK: ev_id = lo555_reg;
							`CODE_BLANK_CHECK: begin
								ev_blank = lo555_reg;
								ld_sector = lo555_reg;
							end
							`CODE_ERASE_STATUS: begin
								ev_status = lo555_reg;
								ld_sector = lo555_reg;
							end
							`CODE_ERASE_SUSPEND: ev_esusp = 1'b1;
							`CODE_ERASE_RESUME: ev_eres = 1'b1;
							`CODE_PROG_SUSPEND: ev_psusp = 1'b1;
							`CODE_PROG_RESUME: ev_pres = 1'b1;
							default: state_next = ST_IDLE;
						endcase
					end
				end
				ST_UNLOCK1: begin
					state_next = is_code_55 ? ST_UNLOCK2 : ST_IDLE;
				end
				ST_UNLOCK2: begin
					state_next = ST_IDLE;
					if (fit_reg && code_reg == `CODE_BUF_LOAD) begin
						state_next = ST_BUF_COUNT;
						ld_sector = 1'b1;
					end else if (fit_reg && lo555_reg && code_reg == `CODE_ERASE_SETUP) begin
						state_next = ST_ERASE_SETUP;
					end else if (fit_reg && lo555_reg && code_reg == `CODE_ID_ENTRY) begin
						ev_id = 1'b1;
					end
				end
				ST_ERASE_SETUP: begin
					state_next = is_code_aa ? ST_ERASE_UNLOCK1 : ST_IDLE;
				end
				ST_ERASE_UNLOCK1: begin
					state_next = is_code_55 ? ST_ERASE_UNLOCK2 : ST_IDLE;
				end
				ST_ERASE_UNLOCK2: begin
					state_next = ST_IDLE;
					ev_chip = fit_reg && lo555_reg && code_reg == `CODE_CHIP_ERASE;
					ev_sect = fit_reg && code_reg == `CODE_SECTOR_ERASE;
					ld_sector = ev_sect;
				end
				ST_BUF_COUNT: begin
					// a broken load leaves the buffer aborted, not idle
					if (fit_reg && same_sector) begin
						state_next = ST_BUF_DATA;
						ld_count = 1'b1;
					end else begin
						state_next = ST_ABORTED;
					end
				end
				ST_BUF_DATA: begin
					if (fit_reg) begin
						ev_word = 1'b1;
						if (left_reg == '0) begin
							state_next = ST_BUF_CONFIRM;
						end
					end else begin
						state_next = ST_ABORTED;
					end
				end
				ST_BUF_CONFIRM: begin
					if (fit_reg && same_sector && code_reg == `CODE_BUF_CONFIRM) begin
						ev_prog = 1'b1;
						state_next = ST_IDLE;
					end else begin
						state_next = ST_ABORTED;
					end
				end
				ST_ABORTED: begin
					state_next = is_code_aa ? ST_ABORT_UNLOCK1 : ST_ABORTED;
				end
				ST_ABORT_UNLOCK1: begin
					state_next = is_code_55 ? ST_ABORT_UNLOCK2 : ST_ABORTED;
				end
				ST_ABORT_UNLOCK2: begin
					if (fit_reg && code_reg == `CODE_ABORT_RESET) begin
						ev_abort_done = 1'b1;
						state_next = ST_IDLE;
					end else begin
						state_next = ST_ABORTED;
					end
				end
				default: state_next = ST_IDLE;
			endcase
		end
	end

	// device reset on the link wins over any cycle in flight
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
		end else if (!lrst_n_s) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			load_sector_reg <= '0;
			op_sector_addr <= '0;
		end else if (ld_sector && lrst_n_s) begin
			load_sector_reg <= sector_reg;
			op_sector_addr <= sector_reg;
		end
	end

	// count holds words minus one, so the last data cycle sees zero
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			left_reg <= '0;
			buffer_word_count <= '0;
		end else if (ld_count && lrst_n_s) begin
			left_reg <= word_reg;
			buffer_word_count <= word_reg;
		end else if (ev_word && left_reg != '0) begin
			left_reg <= left_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			buffer_location_addr <= '0;
			program_word <= '0;
		end else if (ev_word) begin
			buffer_location_addr <= addr_reg;
			program_word <= word_reg;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			buffer_program_start <= 1'b0;
			chip_erase_start <= 1'b0;
			sector_erase_start <= 1'b0;
			blank_check_start <= 1'b0;
			erase_status_start <= 1'b0;
			erase_suspend_req <= 1'b0;
			erase_resume_req <= 1'b0;
			program_suspend_req <= 1'b0;
			program_resume_req <= 1'b0;
			id_space_enter <= 1'b0;
			buffer_abort_done <= 1'b0;
			buffer_word_strobe <= 1'b0;
		end else begin
			buffer_program_start <= ev_prog && lrst_n_s;
			chip_erase_start <= ev_chip && lrst_n_s;
			sector_erase_start <= ev_sect && lrst_n_s;
			blank_check_start <= ev_blank && lrst_n_s;
			erase_status_start <= ev_status && lrst_n_s;
			erase_suspend_req <= ev_esusp && lrst_n_s;
			erase_resume_req <= ev_eres && lrst_n_s;
			program_suspend_req <= ev_psusp && lrst_n_s;
			program_resume_req <= ev_pres && lrst_n_s;
			id_space_enter <= ev_id && lrst_n_s;
			buffer_abort_done <= ev_abort_done && lrst_n_s;
			buffer_word_strobe <= ev_word && lrst_n_s;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			buffer_aborted <= 1'b0;
			seq_busy <= 1'b0;
		end else begin
			buffer_aborted <= lrst_n_s && (state_next == ST_ABORTED
				|| state_next == ST_ABORT_UNLOCK1 || state_next == ST_ABORT_UNLOCK2);
			seq_busy <= lrst_n_s && state_next != ST_IDLE;
		end
	end

	a_link_reset_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		!lrst_n_s |=> state_reg == ST_IDLE)
		else $error("link reset did not return decoder to idle");

	a_unlock_mismatch: assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_reg && state_reg == ST_UNLOCK1 && !is_code_55 |=> state_reg == ST_IDLE)
		else $error("bad second unlock cycle did not return to idle");

	a_chip_erase_cause: assert property (@(posedge mclk) disable iff (!reset_n)
		chip_erase_start |-> $past(state_reg) == ST_ERASE_UNLOCK2
		&& $past(code_reg) == `CODE_CHIP_ERASE && $past(lo555_reg))
		else $error("chip erase started outside six-cycle sequence");

	a_sector_erase_cause: assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_reg && lrst_n_s && state_reg == ST_ERASE_UNLOCK2 && fit_reg
		&& code_reg == `CODE_SECTOR_ERASE |=> sector_erase_start && op_sector_addr == $past(sector_reg))
		else $error("sector erase not started with its sector");

	a_confirm_cause: assert property (@(posedge mclk) disable iff (!reset_n)
		buffer_program_start |-> $past(state_reg) == ST_BUF_CONFIRM
		&& $past(code_reg) == `CODE_BUF_CONFIRM && $past(same_sector))
		else $error("buffer program started without confirm");

	a_abort_exit: assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_reg && lrst_n_s && state_reg == ST_ABORT_UNLOCK2 && fit_reg
		&& code_reg == `CODE_ABORT_RESET |=> buffer_abort_done && state_reg == ST_IDLE)
		else $error("abort reset did not leave aborted state");

	a_resume_idle: assert property (@(posedge mclk) disable iff (!reset_n)
		erase_resume_req |-> $past(state_reg) == ST_IDLE && $past(fit_reg))
		else $error("erase resume taken inside a sequence");

	a_id_entry: assert property (@(posedge mclk) disable iff (!reset_n)
		id_space_enter |-> $past(lo555_reg) && ($past(code_reg) == `CODE_ID_QUICK
		|| $past(state_reg) == ST_UNLOCK2))
		else $error("identification entry without its pattern");

	a_type_gate: assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_reg && !fit_reg && state_reg == ST_IDLE
		|=> !seq_busy && !erase_suspend_req && !program_suspend_req)
		else $error("cycle of wrong type or device advanced decoder");
endmodule

// ==== hw/flash_cmd_consts.svh ====
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// command/address word layout
`define CA_W 48
`define DQ_W 16
`define TYPE_HI 47
`define TYPE_LO 45
`define DSEL_HI 44
`define DSEL_LO 43
`define ADDR_W 43
`define LOW_HI 11
`define SECT_LSB 17
`define SECT_W 26
`define CODE_W 8

// field values
`define TYPE_WRITE 3'h1
`define DSEL_OWN 2'h0
`define LOW_555 12'h555
`define LOW_2AA 12'h2AA

// command codes on the low data byte
`define CODE_UNLOCK1 8'hAA
`define CODE_UNLOCK2 8'h55
`define CODE_BUF_LOAD 8'h25
`define CODE_BUF_CONFIRM 8'h29
`define CODE_ABORT_RESET 8'hF0
`define CODE_ERASE_SETUP 8'h80
`define CODE_CHIP_ERASE 8'h10
`define CODE_SECTOR_ERASE 8'h30
`define CODE_BLANK_CHECK 8'h33
`define CODE_ERASE_STATUS 8'hD0
`define CODE_ERASE_SUSPEND 8'hB0
`define CODE_ERASE_RESUME 8'h30
`define CODE_PROG_SUSPEND 8'h51
`define CODE_PROG_RESUME 8'h50
`define CODE_ID_ENTRY 8'h90
`define CODE_ID_QUICK 8'h98

// synchronised pin vector: {reset_n, sel_n, clk, ca, dq}
`define PIN_W 67

`endif

// ==== hw/flash_cmd_pkg.sv ====
package flash_cmd_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_UNLOCK1,
		ST_UNLOCK2,
		ST_ERASE_SETUP,
		ST_ERASE_UNLOCK1,
		ST_ERASE_UNLOCK2,
		ST_BUF_COUNT,
		ST_BUF_DATA,
		ST_BUF_CONFIRM,
		ST_ABORTED,
		ST_ABORT_UNLOCK1,
		ST_ABORT_UNLOCK2
	} decoder_state_type;

endpackage

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"

module pin_sync (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [`PIN_W-1:0] pins,
	output logic [`PIN_W-1:0] pins_sync
);
	logic [`PIN_W-1:0] meta_reg;

	// first stage is read by the second stage only
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			pins_sync <= '0;
		end else begin
			meta_reg <= pins;
			pins_sync <= meta_reg;
		end
	end
endmodule

// ==== hw/cycle_fields.sv ====
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"

module cycle_fields (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic take,
	input wire logic [`CA_W-1:0] ca,
	input wire logic [`DQ_W-1:0] dq,
	output logic cyc_reg,
	output logic fit_reg,
	output logic lo555_reg,
	output logic lo2aa_reg,
	output logic [`CODE_W-1:0] code_reg,
	output logic [`DQ_W-1:0] word_reg,
	output logic [`ADDR_W-1:0] addr_reg,
	output logic [`SECT_W-1:0] sector_reg
);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_reg <= 1'b0;
		end else begin
			cyc_reg <= take;
		end
	end

	// upper address bits are never compared for unlock patterns
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fit_reg <= 1'b0;
			lo555_reg <= 1'b0;
			lo2aa_reg <= 1'b0;
			code_reg <= '0;
			word_reg <= '0;
			addr_reg <= '0;
			sector_reg <= '0;
		end else if (take) begin
			fit_reg <= (ca[`TYPE_HI:`TYPE_LO] == `TYPE_WRITE)
				&& (ca[`DSEL_HI:`DSEL_LO] == `DSEL_OWN);
			lo555_reg <= (ca[`LOW_HI:0] == `LOW_555);
			lo2aa_reg <= (ca[`LOW_HI:0] == `LOW_2AA);
			code_reg <= dq[`CODE_W-1:0];
			word_reg <= dq;
			addr_reg <= ca[`ADDR_W-1:0];
			sector_reg <= ca[`ADDR_W-1:`SECT_LSB];
		end
	end
endmodule

// ==== testbench/flash_host_model.sv ====
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"

module flash_host_model (
	input wire logic mclk,
	output logic link_clk,
	output logic link_sel_n,
	output logic link_reset_n,
	output logic [`CA_W-1:0] ca,
	output logic [`DQ_W-1:0] dq
);
	initial begin
		link_clk = 0;
		link_sel_n = 1;
		link_reset_n = 1;
		ca = '0;
		dq = '0;
	end

	// one write cycle; link clock only toggles inside the frame, 125 ns period
	task automatic cycle(input logic [`CA_W-1:0] c, input logic [`DQ_W-1:0] d);
		@(negedge mclk);
		link_sel_n = 0;
		ca = c;
		dq = d;
		repeat (12) @(negedge mclk);
		link_clk = 1;
		repeat (13) @(negedge mclk);
		link_clk = 0;
		@(negedge mclk);
		link_sel_n = 1;
		// released lines show the inverse so stale values cannot pass
		ca = ~c;
		dq = ~d;
	endtask

	// drive the device reset pin, then leave time for the far synchroniser
	task automatic pin_reset(input logic v);
		@(negedge mclk);
		link_reset_n = v;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// ==== testbench/flash_cmd_sequence_decoder_tb.sv ====
`timescale 1ns/1ps
`include "flash_cmd_consts.svh"

module flash_cmd_sequence_decoder_tb;
	logic mclk, reset_n, lclk, lsel_n, lrst_n;
	logic [47:0] ca, c;
	logic [15:0] dq;
	logic bps, ces, ses, bcs, ess, esr, err, psr, prr, ide, abd, wst, sabt, busy;
	logic [42:0] loc, rloc;
	logic [15:0] pw, wc, rcnt, rword;
	logic [25:0] osa, rop, rsec, sa, sb;
	wire [11:0] pulses = {wst, abd, ide, prr, psr, err, esr, ess, bcs, ses, ces, bps};
	logic [11:0] seen, e;
	integer seed = 87678;
	int miscompares, compares, st, i, j;
	logic [15:0] bufq [$];
	logic [7:0] codes [15] = '{8'h33, 8'hD0, 8'hB0, 8'h30, 8'h51, 8'h50, 8'h98, 8'hAA,
		8'h55, 8'h25, 8'h29, 8'hF0, 8'h80, 8'h10, 8'h90};

	flash_cmd_sequence_decoder u_flash_cmd_sequence_decoder (.mclk(mclk), .reset_n(reset_n),
		.link_clk(lclk), .link_sel_n(lsel_n), .link_reset_n(lrst_n), .ca_pins(ca),
		.dq_pins(dq), .buffer_program_start(bps), .chip_erase_start(ces),
		.sector_erase_start(ses), .blank_check_start(bcs), .erase_status_start(ess),
		.erase_suspend_req(esr), .erase_resume_req(err), .program_suspend_req(psr),
		.program_resume_req(prr), .id_space_enter(ide), .buffer_abort_done(abd),
		.buffer_word_strobe(wst), .buffer_location_addr(loc), .program_word(pw),
		.op_sector_addr(osa), .buffer_word_count(wc), .buffer_aborted(sabt), .seq_busy(busy));
	flash_host_model u_flash_host_model (.mclk(mclk), .link_clk(lclk), .link_sel_n(lsel_n),
		.link_reset_n(lrst_n), .ca(ca), .dq(dq));

	initial begin
		mclk = 0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) seen = seen | pulses;

	function automatic logic [47:0] mk(input logic [25:0] s, input logic [11:0] lo);
		// bits 16:12 are don't-care and get noise
		mk = {3'h1, 2'h0, s, 5'($random(seed)), lo};
	endfunction

	task check(input string n, input logic [42:0] s, input logic [42:0] x);
		compares++;
		if (s !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask

	task stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// reference sequencer: 0 idle,1-2 unlock,3-5 erase,6-8 buffer,9-11 aborted
	task step(input logic [47:0] c, input logic [15:0] d);
		logic ok, l5, l2;
		logic [7:0] k;
		logic [25:0] s;
		ok = c[47:45] == 3'h1 && c[44:43] == 2'h0;
		l5 = c[11:0] == 12'h555;
		l2 = c[11:0] == 12'h2AA;
		k = d[7:0];
		s = c[42:17];
		e = 0;
		case (st)
			0: if (ok) begin
				if (k == 8'hAA && l5) st = 1;
				else if ((k == 8'h33 || k == 8'hD0) && l5) begin
					e[3] = k == 8'h33;
					e[4] = k == 8'hD0;
					rop = s;
				end
				else if (k == 8'h98 && l5) e[9] = 1;
				else begin
					e[5] = k == 8'hB0;
					e[6] = k == 8'h30;
					e[7] = k == 8'h51;
					e[8] = k == 8'h50;
				end
			end
			1: st = (ok && k == 8'h55 && l2) ? 2 : 0;
			2: begin
				st = 0;
				if (ok && k == 8'h25) begin
					st = 6;
					rop = s;
					rsec = s;
				end
				else if (ok && k == 8'h80 && l5) st = 3;
				else if (ok && k == 8'h90 && l5) e[9] = 1;
			end
			3: st = (ok && k == 8'hAA && l5) ? 4 : 0;
			4: st = (ok && k == 8'h55 && l2) ? 5 : 0;
			5: begin
				st = 0;
				if (ok && k == 8'h10 && l5) e[1] = 1;
				else if (ok && k == 8'h30) begin
					e[2] = 1;
					rop = s;
				end
			end
			6: if (ok && s == rsec) begin
				rcnt = d;
				bufq = {};
				st = 7;
			end
			else st = 9;
			7: if (ok) begin
				e[11] = 1;
				rword = d;
				rloc = c[42:0];
				bufq.push_back(d);
				if (bufq.size() == rcnt + 1) st = 8;
			end
			else st = 9;
			8: begin
				e[0] = ok && k == 8'h29 && s == rsec;
				st = e[0] ? 0 : 9;
			end
			9: st = (ok && k == 8'hAA && l5) ? 10 : 9;
			10: st = (ok && k == 8'h55 && l2) ? 11 : 9;
			default: begin
				e[10] = ok && k == 8'hF0;
				st = e[10] ? 0 : 9;
			end
		endcase
	endtask

	task send(input logic [47:0] c, input logic [15:0] d);
		@(negedge mclk);
		seen = 0;
		u_flash_host_model.cycle(c, d);
		step(c, d);
		check("pulses", seen, e);
		check("busy", busy, st != 0);
		check("aborted", sabt, st >= 9);
		check("sector", osa, rop);
		check("count", wc, rcnt);
		check("word", pw, rword);
		check("location", loc, rloc);
	endtask

	task unl;
		send(mk(26'($random(seed)), 12'h555), 16'h00AA);
		send(mk(26'($random(seed)), 12'h2AA), 16'h0055);
	endtask

	initial begin
		reset_n = 0;
		{seen, e, rop, rcnt, rword, rloc, rsec, st, compares, miscompares} = '0;
		sa = 26'($random(seed));
		sb = sa ^ 26'h1;
		repeat (8) @(posedge mclk);
		@(negedge mclk) reset_n = 1;
		for (j = 0; j < 2; j++)
			for (i = 0; i < 7; i++)
				send(mk(sa, j ? 12'h2AA : 12'h555), {8'h00, codes[i]});
		unl;
		send(mk(sa, 12'h555), 16'h0090);
		for (j = 0; j < 2; j++) begin
			unl;
			send(mk(sa, 12'h555), 16'h0080);
			unl;
			send(mk(sb, j ? 12'h123 : 12'h555), j ? 16'h0030 : 16'h0010);
		end
		for (j = 0; j < 4; j++) begin
			unl;
			send(mk(sb, 12'h321), 16'h0025);
			send(mk(sb, 12'h0F0), 16'(j));
			for (i = 0; i <= j; i++)
				send({3'h1, 2'h0, 43'($random(seed))}, 16'($random(seed)));
			send(mk(sb, 12'h000), 16'h0029);
		end
		unl;
		send(mk(sa, 12'h555), 16'h0025);
		send(mk(sa, 12'h555), 16'h0001);
		send({3'h5, 2'h0, 43'h0}, 16'h1234);
		send(mk(sa, 12'h555), 16'h00AA);
		send(mk(sa, 12'h555), 16'h0051);
		unl;
		send({3'h1, 2'h0, 43'($random(seed))}, 16'h00F0);
		unl;
		send({3'h1, 2'h1, 26'(sa), 17'h00555}, 16'h0080);
		send(mk(sa, 12'h555), 16'h0010);
		unl;
		// a cycle taken while the device reset pin is low must start nothing
		u_flash_host_model.pin_reset(1'b0);
		seen = 0;
		u_flash_host_model.cycle(mk(sa, 12'h555), 16'h0098);
		u_flash_host_model.pin_reset(1'b1);
		st = 0;
		check("busy", busy, 1'b0);
		check("pulses", seen, 12'h000);
		send(mk(sa, 12'h555), 16'h0080);
		for (i = 0; i < 250; i++) begin
			j = $random(seed) & 3;
			c = mk(($random(seed) & 1) ? sa : sb, j == 0 ? 12'h555 :
				(j == 1 ? 12'h2AA : 12'($random(seed))));
			if (($random(seed) & 7) == 0)
				c[44] = 1;
			send(c, {8'h00, codes[$unsigned($random(seed)) % 15]});
		end
		stop_test;
	end

	initial begin
		#200000;
		miscompares++;
		stop_test;
	end
endmodule
